// file: tdmp_codec_model.sv
// Far-end codec model: owns the link clock in slave runs, shifts words both ways
`timescale 1ns/1ps
module tdmp_codec_model (
   // Device pins
   input wire logic dev_bclk_i,
   input wire logic dev_bclk_oe_i,
   input wire logic dev_ws_i,
   input wire logic dev_ws_oe_i,
   input wire logic dev_tx_i,
   // Set by the bench
   input wire logic i2s_std_i,
   input wire logic snap_lvl_i,
   input wire logic [15:0] left_i,
   input wire logic [15:0] right_i,
   // Line levels
   output logic bclk_o,
   output logic ws_o,
   output logic rx_o,
   // What the model saw
   output logic [15:0] cap_l_o,
   output logic [15:0] cap_r_o,
   output logic [31:0] snap_o,
   output int hi_len_o,
   output int lo_len_o,
   output int frames_o
);
   logic my_bclk = 1'b0;
   logic my_ws = 1'b0;
   logic ws_seen = 1'b0;
   logic [31:0] sreg = '0;
   int pos = 0;
   int seg = 0;
   int idx;
   int ridx;

   initial begin
      hi_len_o = 0;
      lo_len_o = 0;
      frames_o = 0;
      rx_o = 1'b0;
   end

   // Whoever enables the pins owns them; our clock stands low outside frames
   assign bclk_o = dev_bclk_oe_i ? dev_bclk_i : my_bclk;
   assign ws_o = dev_ws_oe_i ? dev_ws_i : my_ws;

   // Sample device data, measure sync segments, restart count at each sync change
   always @(posedge bclk_o) begin
      if (ws_o !== ws_seen) begin
         if (ws_seen) hi_len_o = seg;
         else lo_len_o = seg;
         if (ws_o === snap_lvl_i) snap_o = sreg;
         if (ws_o) frames_o++;
         seg = 1;
         pos = 0;
         ws_seen = ws_o;
      end else begin
         seg++;
         pos++;
      end
      sreg = {sreg[30:0], dev_tx_i};
      idx = pos - int'(i2s_std_i);
      if (idx >= 0 && idx < 16) begin
         if (ws_o ^ i2s_std_i) cap_l_o[15-idx] = dev_tx_i;
         else cap_r_o[15-idx] = dev_tx_i;
      end
   end

   // Launch on falling edges; past the LSB the line toggles so stale bits show
   always @(negedge bclk_o) begin
      #1;
      ridx = ((ws_o !== ws_seen) ? 0 : pos + 1) - int'(i2s_std_i);
      if (ridx >= 0 && ridx < 16) rx_o = (ws_o ^ i2s_std_i) ? left_i[15-ridx] : right_i[15-ridx];
      else rx_o = ~rx_o;
   end

   // Slave frames at a 400 ns bit period, word select at half the frame
   task automatic run_frames(input int n, input int bpf);
      for (int b = 0; b < n * bpf; b++) begin
         my_bclk = 1'b0;
         my_ws = (b % bpf) >= bpf / 2;
         #200;
         my_bclk = 1'b1;
         #200;
      end
      my_bclk = 1'b0;
   endtask : run_frames
endmodule : tdmp_codec_model

// file: tdmp_pkg.sv
// Package: register map, field layout and encodings of the TDM audio serial port
package tdmp_pkg;
   // Frame formats and sample encodings
   typedef enum logic [1:0] {MODE_I2S, MODE_LJ, MODE_PCM, MODE_GCI} tdmp_mode_t;
   typedef enum logic [1:0] {ENC_ALAW, ENC_ULAW, ENC_LIN, ENC_G722} tdmp_enc_t;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SLOT = 8'h04;
   localparam logic [7:0] OFS_DIV = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_TX0 = 8'h10;
   localparam logic [7:0] OFS_RX0 = 8'h20;
   localparam logic [7:0] OFS_END = 8'h30;
   // Control field positions
   localparam int CTL_EN = 0;
   localparam int CTL_MST = 1;
   localparam int CTL_MODE = 2;
   localparam int CTL_XE = 4;
   localparam int CTL_ENC = 5;
   localparam int CTL_HALF = 7;
   localparam int CTL_BPF = 8;
   localparam int CTL_CHEN = 12;
   // Values after reset
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [31:0] SLOT_RST = 32'h0302_0100;
   localparam logic [15:0] DIV_RST = 16'h0001;
   // Bits per frame, selected by the frame length field
   localparam logic [3:0] BPF_MAX_SEL = 4'hA;
   localparam logic [10:0] BPF_TAB [0:10] = '{11'h008, 11'h010, 11'h020, 11'h040, 11'h060,
      11'h080, 11'h0C0, 11'h100, 11'h180, 11'h200, 11'h400};
   // Word length on the link
   localparam logic [9:0] WORD_BITS = 10'h010;
   // Bus answers
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : tdmp_pkg

// file: tdmp_port.sv
// Module: TDM audio serial port (I2S, left-justified, PCM, GCI) behind AXI4-Lite
`timescale 1ns/1ps
// What this block does
// - I2S: left/right out on tx, in on rx
// - Master drives clock and sync; slave listens
// - Frame holds one left, one right word
// - Master word select has equal halves
// - Bits per frame: 8 up to 1024
// - MSB first; bits after LSB dropped
// - I2S: left on low, MSB one bit late
// - Left-justified: left on high, MSB immediate
// - Each PCM channel has its own slot
// - A-law, mu-law, linear, G.722, shared per bus
// - Linear sample uses slots N and N+1
// - 8/16-bit samples at 8 or 16 kHz
// - G.722 uses one slot per frame
// - Half-frame mode adds pair bpf/16 slots later
// - Slave accepts any frame sync width
// - Master frame sync one bit clock wide
// - PCM/GCI: edge select picks transmit launch edge
// - GCI: clock equals bit rate, plain bytes
// - GCI first bit with sync rising edge
// - Up to four channels, any stream each
module tdmp_port
   import tdmp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Bit clock pin
   input wire logic bit_clk_i,
   output logic bit_clk_o,
   output logic bit_clk_oe_o,
   // Word select / frame sync pin
   input wire logic left_right_select_i,
   output logic left_right_select_o,
   output logic left_right_select_oe_o,
   // Serial data
   input wire logic serial_rx_line_i,
   output logic serial_tx_line_o
);
   // Registers
   logic [15:0] ctrl_q;
   logic [31:0] slot_q;
   logic [15:0] div_q;
   logic [31:0] tx_q [4];
   logic [31:0] rx_q [4];
   logic [31:0] rx_sh_q [4];
   logic [15:0] frames_q;
   logic sync_seen_q;
   logic done_q;
   logic oe_q;

   // Decoded configuration, one setting per bus
   logic en;
   logic mst;
   logic xe;
   logic half_md;
   logic i2s_md;
   logic lj;
   logic [3:0] ch_en;
   logic [3:0] bsel;
   tdmp_mode_t mode;
   tdmp_enc_t enc;
   logic [10:0] bpf;
   logic [9:0] last;
   logic [9:0] half;
   logic [6:0] hslots;
   assign en = ctrl_q[CTL_EN];
   assign mst = ctrl_q[CTL_MST];
   assign xe = ctrl_q[CTL_XE];
   assign half_md = ctrl_q[CTL_HALF];
   assign ch_en = ctrl_q[CTL_CHEN +: 4];
   assign mode = tdmp_mode_t'(ctrl_q[CTL_MODE +: 2]);
   assign enc = tdmp_enc_t'(ctrl_q[CTL_ENC +: 2]);
   assign i2s_md = (mode == MODE_I2S) || (mode == MODE_LJ);
   assign lj = (mode == MODE_LJ);
   assign bsel = (ctrl_q[CTL_BPF +: 4] > BPF_MAX_SEL) ? BPF_MAX_SEL : ctrl_q[CTL_BPF +: 4];
   assign bpf = BPF_TAB[bsel];
   assign last = 10'(bpf - 11'd1);
   assign half = bpf[10:1];
   assign hslots = bpf[10:4];

   // Pin synchronisers; clock and sync share depth so they stay aligned
   logic bc_s1_q, bc_s2_q, bc_s3_q;
   logic ws_s1_q, ws_s2_q;
   logic rx_s1_q, rx_s2_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bc_s1_q <= 1'b0;
         bc_s2_q <= 1'b0;
         bc_s3_q <= 1'b0;
         ws_s1_q <= 1'b0;
         ws_s2_q <= 1'b0;
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
      end else begin
         bc_s1_q <= bit_clk_i;
         bc_s2_q <= bc_s1_q;
         bc_s3_q <= bc_s2_q;
         ws_s1_q <= left_right_select_i;
         ws_s2_q <= ws_s1_q;
         rx_s1_q <= serial_rx_line_i;
         rx_s2_q <= rx_s1_q;
      end
   end

   // Master bit clock divider; half period is div_q core cycles
   logic [15:0] div_cnt_q;
   logic bclk_q;
   logic m_tick;
   assign m_tick = en && mst && (({1'b0, div_cnt_q} + 17'd1) >= {1'b0, div_q});
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_q <= 16'h0000;
         bclk_q <= 1'b0;
      end else if (!(en && mst)) begin
         div_cnt_q <= 16'h0000;
         bclk_q <= 1'b0;
      end else if (m_tick) begin
         div_cnt_q <= 16'h0000;
         bclk_q <= !bclk_q;
      end else begin
         div_cnt_q <= div_cnt_q + 16'd1;
      end
   end

   // Bit clock edges as one-cycle enables, from divider or from the pin
   logic rise_ev;
   logic fall_ev;
   assign rise_ev = mst ? (m_tick && !bclk_q) : (en && bc_s2_q && !bc_s3_q);
   assign fall_ev = mst ? (m_tick && bclk_q) : (en && !bc_s2_q && bc_s3_q);

   // Slave sync detection: any WS change, or only the rising FS edge so width is free
   logic ws_prev_q;
   logic sync_edge;
   logic [9:0] start_pos;
   assign sync_edge = !mst && rise_ev &&
      (i2s_md ? (ws_s2_q != ws_prev_q) : (ws_s2_q && !ws_prev_q));
   always_comb begin
      if (i2s_md) begin
         start_pos = (ws_s2_q == lj) ? 10'd0 : half;
      end else if (mode == MODE_PCM) begin
         start_pos = last;
      end else begin
         start_pos = 10'd0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ws_prev_q <= 1'b0;
      end else if (!mst && rise_ev) begin
         ws_prev_q <= ws_s2_q;
      end
   end

   // Bit position in the frame; advances on falling edges
   logic [9:0] pos_q;
   logic [9:0] cur_pos;
   logic [9:0] nxt_pos;
   assign cur_pos = sync_edge ? start_pos : pos_q;
   assign nxt_pos = (pos_q >= last) ? 10'd0 : 10'(pos_q + 10'd1);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_q <= 10'd0;
      end else if (!en) begin
         pos_q <= last;
      end else if (sync_edge) begin
         pos_q <= start_pos;
      end else if (fall_ev) begin
         pos_q <= nxt_pos;
      end
   end

   // Map a bit position to {valid, channel, bit index}
   function automatic logic [7:0] slot_map(input logic [9:0] p);
      logic [9:0] off;
      logic [9:0] d;
      logic [7:0] s;
      logic [7:0] b;
      logic [7:0] r;
      off = 10'd0;
      d = 10'd0;
      s = {1'b0, p[9:3]};
      b = 8'h00;
      r = 8'h00;
      if (i2s_md) begin
         off = (p >= half) ? 10'(p - half) : p;
         d = lj ? off : 10'(off - 10'd1);
         // Positions past the LSB carry nothing
         if ((lj || off != 10'd0) && d < WORD_BITS) begin
            r = {1'b1, 1'b0, (p >= half), 5'(5'd15 - d[4:0])};
         end
      end else begin
         // Lowest channel wins if two share a slot
         for (int c = 3; c >= 0; c--) begin
            b = slot_q[8*c +: 8];
            if (ch_en[c]) begin
               if (enc != ENC_LIN) begin
                  if (s == b) begin
                     r = {1'b1, 2'(c), 5'(5'd7 - {2'b00, p[2:0]})};
                  end
               end else if (s == b) begin
                  r = {1'b1, 2'(c), 5'(5'd15 - {2'b00, p[2:0]})};
               end else if (s == 8'(b + 8'd1)) begin
                  r = {1'b1, 2'(c), 5'(5'd7 - {2'b00, p[2:0]})};
               end else if (half_md && s == 8'(b + {1'b0, hslots})) begin
                  r = {1'b1, 2'(c), 5'(5'd31 - {2'b00, p[2:0]})};
               end else if (half_md && s == 8'(b + {1'b0, hslots} + 8'd1)) begin
                  r = {1'b1, 2'(c), 5'(5'd23 - {2'b00, p[2:0]})};
               end
            end
         end
      end
      return r;
   endfunction : slot_map

   // Transmit launch: falling edge, or rising edge when the timeslot edge select is set in PCM or GCI mode
   logic xe_act;
   logic launch;
   logic [9:0] tx_pos;
   logic [7:0] tx_map;
   logic tx_bit;
   assign xe_act = xe && !i2s_md;
   assign launch = xe_act ? rise_ev : fall_ev;
   assign tx_pos = xe_act ? cur_pos : nxt_pos;
   always_comb tx_map = slot_map(tx_pos); // Also wakes on config read in the call
   assign tx_bit = tx_map[7] && tx_q[tx_map[6:5]][tx_map[4:0]];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_tx_line_o <= 1'b0;
      end else if (!en) begin
         serial_tx_line_o <= 1'b0;
      end else if (launch) begin
         serial_tx_line_o <= tx_bit;
      end
   end

   // Master word select / frame sync, changed on falling edges
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left_right_select_o <= 1'b0;
      end else if (!(en && mst)) begin
         left_right_select_o <= 1'b0;
      end else if (fall_ev) begin
         if (i2s_md) begin
            left_right_select_o <= (nxt_pos >= half) ^ lj;
         end else if (mode == MODE_PCM) begin
            left_right_select_o <= (nxt_pos == last);
         end else begin
            left_right_select_o <= (nxt_pos == 10'd0);
         end
      end
   end

   // Pin drivers follow master mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= en && mst;
      end
   end
   assign bit_clk_o = bclk_q;
   assign bit_clk_oe_o = oe_q;
   assign left_right_select_oe_o = oe_q;

   // Receive: sample on rising edges, publish the whole frame at its end
   logic [7:0] rx_map;
   always_comb rx_map = slot_map(cur_pos);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 4; i++) begin
            rx_sh_q[i] <= 32'h0000_0000;
            rx_q[i] <= 32'h0000_0000;
         end
      end else begin
         if (rise_ev && rx_map[7]) begin
            rx_sh_q[rx_map[6:5]][rx_map[4:0]] <= rx_s2_q;
         end
         if (done_q) begin
            for (int i = 0; i < 4; i++) begin
               rx_q[i] <= rx_sh_q[i];
            end
         end
      end
   end

   // Frame counter and sync status
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_q <= 1'b0;
         frames_q <= 16'h0000;
         sync_seen_q <= 1'b0;
      end else begin
         done_q <= rise_ev && (cur_pos == last);
         if (done_q) begin
            frames_q <= frames_q + 16'd1;
         end
         if (!en) begin
            sync_seen_q <= 1'b0;
         end else if (sync_edge || (mst && done_q)) begin
            sync_seen_q <= 1'b1;
         end
      end
   end

   // AXI4-Lite write channels; address and data accepted in either order
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   assign wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OK;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            awaddr_q <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (awaddr_q < OFS_END) ? RESP_OK : RESP_ERR;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // Byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = w[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // Register writes; status and receive words are read-only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= CTRL_RST;
         slot_q <= SLOT_RST;
         div_q <= DIV_RST;
         for (int i = 0; i < 4; i++) begin
            tx_q[i] <= 32'h0000_0000;
         end
      end else if (wr_go) begin
         case ({awaddr_q[7:2], 2'b00})
            OFS_CTRL: ctrl_q <= 16'(merge({16'h0000, ctrl_q}, wdata_q, wstrb_q));
            OFS_SLOT: slot_q <= merge(slot_q, wdata_q, wstrb_q);
            OFS_DIV: div_q <= 16'(merge({16'h0000, div_q}, wdata_q, wstrb_q));
            default: begin
               // Words are used live, so update between frames to avoid tearing
               if (awaddr_q[7:4] == OFS_TX0[7:4]) begin
                  tx_q[awaddr_q[3:2]] <= merge(tx_q[awaddr_q[3:2]], wdata_q, wstrb_q);
               end
            end
         endcase
      end
   end

   // Read mux
   logic [31:0] rd_word;
   logic rd_ok;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case ({s_axi_araddr_i[7:2], 2'b00})
         OFS_CTRL: rd_word = {16'h0000, ctrl_q};
         OFS_SLOT: rd_word = slot_q;
         OFS_DIV: rd_word = {16'h0000, div_q};
         OFS_STAT: rd_word = {14'h0000, oe_q, sync_seen_q, frames_q};
         default: begin
            if (s_axi_araddr_i[7:4] == OFS_TX0[7:4]) begin
               rd_word = tx_q[s_axi_araddr_i[3:2]];
            end else if (s_axi_araddr_i[7:4] == OFS_RX0[7:4]) begin
               rd_word = rx_q[s_axi_araddr_i[3:2]];
            end else begin
               rd_ok = 1'b0;
            end
         end
      endcase
   end

   // AXI4-Lite read channel; one read outstanding
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= RESP_OK;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_ws_halves: assert property (en && mst && i2s_md && fall_ev && nxt_pos == half
      |=> left_right_select_o != lj)
      else $error("word select did not switch at half frame");
   chk_fs_width: assert property (en && mst && !i2s_md && left_right_select_o && fall_ev
      |=> !left_right_select_o)
      else $error("frame sync wider than one bit clock");
   chk_frame_wrap: assert property (en && mst && fall_ev && pos_q == last
      |=> pos_q == 10'd0)
      else $error("bit position did not wrap at frame length");
   chk_slave_resync: assert property (sync_edge |=> pos_q == $past(start_pos))
      else $error("slave did not restart at sync");
   chk_launch_edge: assert property (en && $past(en) && $changed(serial_tx_line_o)
      |-> $past(xe_act ? rise_ev : fall_ev))
      else $error("transmit data changed off the selected edge");
   chk_master_clk: assert property (en && mst && rise_ev |=> bit_clk_o && bit_clk_oe_o)
      else $error("master bit clock not driven high");
   chk_gci_align: assert property (en && mst && mode == MODE_GCI && left_right_select_o
      |-> pos_q == 10'd0)
      else $error("GCI sync not on first bit");
   chk_frame_count: assert property (done_q |=> frames_q == 16'($past(frames_q) + 16'd1))
      else $error("frame counter did not advance");

   cov_i2s_frame: cover property (en && mst && i2s_md && done_q);
   cov_slave_pcm: cover property (sync_edge && mode == MODE_PCM);
   cov_xe_launch: cover property (xe_act && rise_ev && tx_map[7]);
endmodule : tdmp_port

// file: tdmp_port_bench.sv
// Self-checking bench for the TDM audio serial port
`timescale 1ns/1ps
module tdmp_port_bench;
   import tdmp_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, t0, t1, d;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, bclk_o, bclk_oe, ws_o, ws_oe, tx, bclk, ws, rx;
   logic [1:0] bresp, rresp, r;
   logic i2s_std = 0, snap_lvl = 0;
   logic [15:0] m_left = '0, m_right = '0, cap_l, cap_r;
   logic [31:0] snap;
   logic [63:0] e;
   int hi_len, lo_len, frames;
   int errors = 0;
   int samples_checked = 0;
   tdmp_mode_t md [5] = '{MODE_PCM, MODE_PCM, MODE_PCM, MODE_PCM, MODE_GCI};
   tdmp_enc_t en [5] = '{ENC_ALAW, ENC_ULAW, ENC_LIN, ENC_LIN, ENC_G722};
   logic hf [5] = '{0, 0, 0, 1, 0};
   int sl [5] = '{0, 3, 1, 0, 2};
   localparam int PB = 32;

   // Core clock, 50 ns
   always #25 clk_i = ~clk_i;

   tdmp_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bit_clk_i(bclk),
      .bit_clk_o(bclk_o), .bit_clk_oe_o(bclk_oe), .left_right_select_i(ws), .left_right_select_o(ws_o),
      .left_right_select_oe_o(ws_oe), .serial_rx_line_i(rx), .serial_tx_line_o(tx));

   tdmp_codec_model partner_u (.dev_bclk_i(bclk_o), .dev_bclk_oe_i(bclk_oe), .dev_ws_i(ws_o),
      .dev_ws_oe_i(ws_oe), .dev_tx_i(tx), .i2s_std_i(i2s_std), .snap_lvl_i(snap_lvl), .left_i(m_left),
      .right_i(m_right), .bclk_o(bclk), .ws_o(ws), .rx_o(rx), .cap_l_o(cap_l), .cap_r_o(cap_r),
      .snap_o(snap), .hi_len_o(hi_len), .lo_len_o(lo_len), .frames_o(frames));

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic timeout(input string what);
      errors++;
      $display("FAIL %0t no answer on %s", $time, what);
      report_and_stop();
   endtask : timeout

   // Write: both channels offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rs = bresp;
      bready <= 1'b0;
      if (n == 100) timeout("write");
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 100) timeout("read");
   endtask : axi_rd

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      axi_wr(a, v, rs);
      chk(32'(rs), 32'(RESP_OK), "write answer");
   endtask : wr

   // Frames are counted by the model on sync rising edges
   task automatic wait_frames(input int k);
      int f0;
      int n;
      f0 = frames;
      for (n = 0; n < 40000 && frames < f0 + k; n++) @(posedge clk_i);
      if (n == 40000) timeout("frames");
   endtask : wait_frames

   function automatic logic [31:0] ctl(input logic mst, input tdmp_mode_t m, input tdmp_enc_t c,
         input logic half, input int sel, input logic [3:0] chen);
      logic [31:0] v;
      v = '0;
      v[CTL_EN] = 1'b1;
      v[CTL_MST] = mst;
      v[CTL_MODE +: 2] = m;
      v[CTL_ENC +: 2] = c;
      v[CTL_HALF] = half;
      v[CTL_BPF +: 4] = 4'(sel);
      v[CTL_CHEN +: 4] = chen;
      return v;
   endfunction : ctl

   // Expected frame bits {mask, value}; slot 0 is the first bit after sync
   function automatic logic [63:0] slot_exp(input tdmp_enc_t c, input logic half, input int s,
         input logic [31:0] t);
      logic [31:0] m;
      logic [31:0] x;
      m = '0;
      x = '0;
      if (c == ENC_LIN) begin
         x[31-8*s -: 16] = t[15:0];
         m[31-8*s -: 16] = 16'hFFFF;
         if (half) begin
            x[31-8*(s+PB/16) -: 16] = t[31:16];
            m[31-8*(s+PB/16) -: 16] = 16'hFFFF;
         end
      end else begin
         x[31-8*s -: 8] = t[7:0];
         m[31-8*s -: 8] = 8'hFF;
      end
      return {m, x};
   endfunction : slot_exp

   task automatic check_i2s(input logic mst);
      chk({31'h0, bclk_oe}, {31'h0, mst}, "pin drive");
      chk(32'(hi_len), 32'h20, "ws high length");
      chk(32'(lo_len), 32'h20, "ws low length");
      chk({16'h0, cap_l}, {16'h0, t0[15:0]}, "left out");
      chk({16'h0, cap_r}, {16'h0, t1[15:0]}, "right out");
      axi_rd(OFS_RX0, d, r);
      chk({16'h0, d[15:0]}, {16'h0, m_left}, "left in");
      axi_rd(OFS_RX0 + 8'h04, d, r);
      chk({16'h0, d[15:0]}, {16'h0, m_right}, "right in");
   endtask : check_i2s

   task automatic load_words();
      t0 = $urandom();
      t1 = $urandom();
      m_left <= 16'($urandom());
      m_right <= 16'($urandom());
      wr(OFS_TX0, t0);
      wr(OFS_TX0 + 8'h04, t1);
   endtask : load_words

   // Main sequence
   initial begin
      void'($urandom(32'hb52f));
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      axi_rd(OFS_CTRL, d, r);
      chk(d, 32'(CTRL_RST), "ctrl after reset");
      axi_rd(OFS_SLOT, d, r);
      chk(d, SLOT_RST, "slot after reset");
      axi_rd(OFS_DIV, d, r);
      chk(d, 32'(DIV_RST), "div after reset");
      axi_rd(OFS_END, d, r);
      chk({r, d[29:0]}, {RESP_ERR, 30'h0}, "unmapped read");
      axi_wr(OFS_END, 32'h1, r);
      chk(32'(r), 32'(RESP_ERR), "unmapped write");
      chk(32'({bclk_oe, ws_oe, tx}), 32'h0, "idle pins");
      $display("test registers done");
      // Master stereo, standard then left-justified, 64 bits per frame
      wr(OFS_DIV, 32'h4);
      for (int k = 0; k < 2; k++) begin
         i2s_std <= (k == 0);
         load_words();
         wr(OFS_CTRL, ctl(1'b1, k == 0 ? MODE_I2S : MODE_LJ, ENC_LIN, 1'b0, 3, 4'h3));
         wait_frames(3);
         check_i2s(1'b1);
         wr(OFS_CTRL, 32'h0);
      end
      $display("test master stereo done");
      // Master sync pulse over every frame length; lengths keep whole slots
      wr(OFS_DIV, 32'h1);
      for (int s = 0; s <= 10; s++) begin
         wr(OFS_CTRL, ctl(1'b1, MODE_PCM, ENC_ALAW, 1'b0, s, 4'h1));
         wait_frames(3);
         chk(32'(hi_len), 32'h1, "sync width");
         chk(32'(hi_len + lo_len), 32'(BPF_TAB[s]), "bits per frame");
         wr(OFS_CTRL, 32'h0);
      end
      $display("test frame lengths done");
      // Timeslot placement for each encoding
      for (int c = 0; c < 5; c++) begin
         t0 = $urandom();
         snap_lvl <= (md[c] == MODE_GCI);
         wr(OFS_TX0, t0);
         wr(OFS_SLOT, {SLOT_RST[31:8], 8'(sl[c])});
         wr(OFS_CTRL, ctl(1'b1, md[c], en[c], hf[c], 2, 4'h1));
         wait_frames(3);
         e = slot_exp(en[c], hf[c], sl[c], t0);
         chk(snap & e[63:32], e[31:0], "slot data");
         wr(OFS_CTRL, 32'h0);
      end
      $display("test timeslots done");
      // Far end drives clock and word select
      i2s_std <= 1'b1;
      load_words();
      wr(OFS_CTRL, ctl(1'b0, MODE_I2S, ENC_LIN, 1'b0, 3, 4'h3));
      partner_u.run_frames(3, 64);
      repeat (20) @(posedge clk_i);
      check_i2s(1'b0);
      $display("test slave stereo done");
      report_and_stop();
   end
endmodule : tdmp_port_bench
